// [hdl/ldch_pkg.sv]
// Purpose: constants and types for the link diagnostic command handler
// Assumes: parsed commands with arguments, byte-serial payload and response streams, one clock
// Notes: Function list below
package ldch_pkg;
  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam logic [3:0] CMD_LINK_STATUS = 4'h1;
  localparam logic [3:0] CMD_ECHO = 4'h2;
  localparam logic [3:0] CMD_BC_RESULTS = 4'h3;
  localparam logic [3:0] CMD_BC_SEND = 4'h4;
  localparam logic [3:0] CMD_LOG_READ = 4'h5;
  localparam logic [3:0] CMD_LOG_CLEAR = 4'h6;
  // ----------------------------------------
  // Completion codes
  // ----------------------------------------
  localparam logic [1:0] END_NORMAL = 2'h0;
  localparam logic [1:0] END_RANGE_OVF = 2'h1;
  localparam logic [1:0] END_LEN_OVF = 2'h2;
  // ----------------------------------------
  // Sizes and limits
  // ----------------------------------------
  localparam int NODES = 62;
  localparam logic [5:0] NODE_FIRST = 6'h01;
  localparam logic [5:0] NODE_LAST = 6'h3e;
  localparam int STATUS_BYTES = 31;
  localparam int ECHO_MAX = 512;
  localparam logic [9:0] ECHO_MAX_W = 10'h200;
  localparam int LOG_DEPTH = 39;
  localparam logic [15:0] LOG_CAPACITY = 16'h0027;
  localparam int REC_BYTES = 10;
  localparam logic [3:0] REC_LAST = 4'h9;
  localparam logic [9:0] RESP_MAX_BYTES = 10'h21c;
  localparam logic [9:0] LOG_HDR_BYTES = 10'h008;
  localparam logic [15:0] REFRESH_MIN = 16'h0005;
  localparam logic [15:0] REFRESH_MAX = 16'h00ff;
  localparam int REFRESH_UNIT_US = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_CYCLES = (REFRESH_UNIT_US * 1000) / CLK_PERIOD_NS;
  localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);
  localparam logic [5:0] BC_NODE = 6'h3f;
  localparam logic [15:0] RESET_SYNC_INIT = 16'h0000;
  localparam logic [7:0] BC_COUNT_MAX = 8'hff;
  localparam logic [15:0] REFRESH_RESET = 16'h0000;
endpackage

// [hdl/ldch_refresh_timer.sv]
// Purpose: measures data link refresh period in 1 ms units
// Assumes: cycle_done_in pulses once per refresh cycle
// Notes: values held while link halted
`timescale 1ns/1ps
`default_nettype none
module ldch_refresh_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Link events
  input wire logic link_run_in,
  input wire logic cycle_done_in,
  // Figures
  output logic [15:0] present_out,
  output logic [15:0] max_out
);
  // ----------------------------------------
  // Millisecond divider
  // ----------------------------------------
  logic [13:0] div_reg;
  logic [15:0] ms_reg;
  logic [15:0] clamped;
  wire ms_tick = (div_reg == ldch_pkg::MS_LAST);
  // Clamp keeps the documented range
  assign clamped = (ms_reg < ldch_pkg::REFRESH_MIN) ? ldch_pkg::REFRESH_MIN :
                   (ms_reg > ldch_pkg::REFRESH_MAX) ? ldch_pkg::REFRESH_MAX : ms_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_reg <= 14'h0000;
      ms_reg <= ldch_pkg::REFRESH_RESET;
      present_out <= ldch_pkg::REFRESH_RESET;
      max_out <= ldch_pkg::REFRESH_RESET;
    end
    else if (link_run_in)
    begin
      div_reg <= ms_tick ? 14'h0000 : div_reg + 14'h0001;
      if (cycle_done_in)
      begin
        ms_reg <= 16'h0000;
        present_out <= clamped;
        if (clamped > max_out)
          max_out <= clamped;
      end
      else if (ms_tick && ms_reg != 16'hffff)
        ms_reg <= ms_reg + 16'h0001;
    end
    // Halted: no update at all
  end
endmodule
`default_nettype wire

// [hdl/ldch_error_log.sv]
// Purpose: error log store, 39 records of ten bytes
// Assumes: records written whole by the unit's fault logic
// Notes: oldest record dropped when full
`timescale 1ns/1ps
`default_nettype none
module ldch_error_log (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write side
  input wire logic wr_in,
  input wire logic [79:0] rec_in,
  input wire logic clear_in,
  // Read side
  input wire logic [5:0] rd_idx_in,
  output logic [79:0] rec_out,
  output logic [5:0] count_out
);
  // ----------------------------------------
  // Storage, record 0 is the oldest
  // ----------------------------------------
  logic [79:0] mem_reg [ldch_pkg::LOG_DEPTH];
  wire full = (count_out == 6'(ldch_pkg::LOG_DEPTH));
  genvar g;
  generate
    for (g = 0; g < ldch_pkg::LOG_DEPTH; g++)
    begin : g_rec
      // Write during clear lands as record zero, so no fault goes unlogged
      wire shift_in = wr_in && full && !clear_in;
      wire load_here = wr_in && (clear_in ? (g == 0) :
                       full ? (g == ldch_pkg::LOG_DEPTH - 1) : (count_out == 6'(g)));
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          mem_reg[g] <= 80'h0;
        else if (load_here)
          mem_reg[g] <= rec_in;
        else if (shift_in && g < ldch_pkg::LOG_DEPTH - 1)
          mem_reg[g] <= mem_reg[(g + 1) % ldch_pkg::LOG_DEPTH];
      end
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count_out <= 6'h00;
    else if (clear_in)
      count_out <= wr_in ? 6'h01 : 6'h00;
    else if (wr_in && !full)
      count_out <= count_out + 6'h01;
  end
  // Index 0 is record number zero
  assign rec_out = (rd_idx_in < 6'(ldch_pkg::LOG_DEPTH)) ? mem_reg[rd_idx_in] : 80'h0;
endmodule
`default_nettype wire

// [hdl/ldch_top.sv]
// Purpose: diagnostic command handler of a network link unit
// Assumes: parsed commands arrive with arguments, payload bytes follow
// Notes: responses leave as a byte stream with valid/ready
`timescale 1ns/1ps
`default_nettype none
module ldch_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Command
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic [15:0] cmd_arg0_in,
  input wire logic [15:0] cmd_arg1_in,
  input wire logic cmd_count_given_in,
  output logic cmd_ready_out,
  // Payload bytes in
  input wire logic pay_valid_in,
  input wire logic [7:0] pay_data_in,
  input wire logic pay_last_in,
  output logic pay_ready_out,
  // Response bytes out
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_last_out,
  output logic [1:0] rsp_end_code_out,
  input wire logic rsp_ready_in,
  // Broadcast delivery to the network
  output logic bc_deliver_out,
  // Link side
  input wire logic link_run_in,
  input wire logic cycle_done_in,
  input wire logic [247:0] node_status_in,
  input wire logic bc_rx_in,
  input wire logic [5:0] bc_rx_node_in,
  // Error log write
  input wire logic log_wr_in,
  input wire logic [79:0] log_rec_in
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ----------------------------------------
  // Link inputs synchronised
  // ----------------------------------------
  logic [1:0] run_sync_reg;
  logic [1:0] done_sync_reg;
  logic done_prev_reg;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_sync_reg <= 2'b00;
      done_sync_reg <= 2'b00;
      done_prev_reg <= 1'b0;
    end
    else
    begin
      run_sync_reg <= {run_sync_reg[0], link_run_in};
      done_sync_reg <= {done_sync_reg[0], cycle_done_in};
      done_prev_reg <= done_sync_reg[1];
    end
  end
  wire link_run = run_sync_reg[1];
  wire cycle_pulse = done_sync_reg[1] && !done_prev_reg;

  // ----------------------------------------
  // Refresh timer and frozen status
  // ----------------------------------------
  logic [15:0] present_ms;
  logic [15:0] max_ms;
  ldch_refresh_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .link_run_in(link_run),
    .cycle_done_in(cycle_pulse),
    .present_out(present_ms),
    .max_out(max_ms)
  );
  logic [247:0] status_reg;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= 248'h0;
    else if (link_run && cycle_pulse)
      status_reg <= node_status_in;
  end

  // ----------------------------------------
  // Broadcast reception counters
  // ----------------------------------------
  logic [7:0] bc_cnt_reg [ldch_pkg::NODES];
  logic bc_clear;
  genvar n;
  generate
    for (n = 0; n < ldch_pkg::NODES; n++)
    begin : g_bc
      wire hit = bc_rx_in && (bc_rx_node_in == 6'(n + 1));
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
          bc_cnt_reg[n] <= 8'h00;
        else if (hit && bc_clear)
          bc_cnt_reg[n] <= 8'h01; // Set wins over clear
        else if (bc_clear)
          bc_cnt_reg[n] <= 8'h00;
        else if (hit && bc_cnt_reg[n] != ldch_pkg::BC_COUNT_MAX)
          bc_cnt_reg[n] <= bc_cnt_reg[n] + 8'h01;
      end
    end
  endgenerate

  // ----------------------------------------
  // Error log
  // ----------------------------------------
  logic [5:0] log_idx_reg;
  logic [79:0] log_rec;
  logic [5:0] log_count;
  logic log_clear;
  ldch_error_log u_log (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .wr_in(log_wr_in),
    .rec_in(log_rec_in),
    .clear_in(log_clear),
    .rd_idx_in(log_idx_reg),
    .rec_out(log_rec),
    .count_out(log_count)
  );

  // ----------------------------------------
  // Error log read planning
  // ----------------------------------------
  wire [15:0] start_rec = cmd_arg0_in;
  wire [15:0] stored16 = {10'h000, log_count};
  wire [15:0] avail = (start_rec < stored16) ? stored16 - start_rec : 16'h0000;
  // Records that fit: (540 - header) / 10
  localparam logic [15:0] FIT_RECS = 16'((ldch_pkg::RESP_MAX_BYTES - ldch_pkg::LOG_HDR_BYTES)
                                         / ldch_pkg::REC_BYTES);
  wire [15:0] want = cmd_count_given_in ? cmd_arg1_in : avail;
  wire short_log = cmd_count_given_in && (want > avail);
  wire [15:0] want_av = short_log ? avail : want;
  // Count above 0027 exceeds the log capacity
  wire too_big = cmd_count_given_in && (cmd_arg1_in > ldch_pkg::LOG_CAPACITY);
  wire [15:0] grant = (want_av > FIT_RECS) ? FIT_RECS : want_av;
  wire [1:0] log_code = too_big ? ldch_pkg::END_LEN_OVF :
                        short_log ? ldch_pkg::END_RANGE_OVF : ldch_pkg::END_NORMAL;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ECHO_IN = 6'b000010,
    S_SEND = 6'b000100,
    S_BC_IN = 6'b001000,
    S_DRAIN = 6'b010000,
    S_DONE = 6'b100000
  } ldch_state_t;
  ldch_state_t state_reg;
  ldch_state_t state_next;
  logic [3:0] op_reg;
  logic [9:0] idx_reg;
  logic [9:0] len_reg;
  logic [3:0] rb_reg;
  logic [7:0] echo_mem [ldch_pkg::ECHO_MAX];
  logic [1:0] code_reg;
  logic [7:0] byte_mux;
  logic [7:0] bc_snap [ldch_pkg::NODES];
  logic [15:0] len_hdr;

  wire take = (state_reg == S_IDLE) && cmd_valid_in;
  wire pay_take = pay_valid_in && pay_ready_out &&
                  ((state_reg == S_ECHO_IN) || (state_reg == S_BC_IN));
  wire echo_room = (idx_reg < ldch_pkg::ECHO_MAX_W);
  wire rsp_fire = rsp_valid_out && rsp_ready_in;
  wire is_last = (idx_reg == len_reg - 10'h001);
  wire [9:0] log_hdr_len = ldch_pkg::LOG_HDR_BYTES;
  wire [5:0] st_node = 6'(idx_reg[5:0] - 6'h04);

  assign cmd_ready_out = (state_reg == S_IDLE);
  assign pay_ready_out = (state_reg == S_BC_IN) || (state_reg == S_DRAIN) ||
                         ((state_reg == S_ECHO_IN) && echo_room);
  assign rsp_valid_out = (state_reg == S_SEND);
  assign rsp_last_out = rsp_valid_out && is_last;
  assign rsp_data_out = byte_mux;
  assign rsp_end_code_out = code_reg;
  assign bc_clear = take && (cmd_code_in == ldch_pkg::CMD_BC_RESULTS);
  assign log_clear = take && (cmd_code_in == ldch_pkg::CMD_LOG_CLEAR);
  // Delivered once the whole payload is in; no answer follows
  assign bc_deliver_out = (state_reg == S_BC_IN) && pay_valid_in && pay_last_in;

  // Response byte selection per command
  always_comb
  begin
    byte_mux = 8'h00;
    case (op_reg)
      ldch_pkg::CMD_LINK_STATUS:
        // Present then max, high byte first, then 31 nibble bytes
        case (idx_reg)
          10'h000: byte_mux = present_ms[15:8];
          10'h001: byte_mux = present_ms[7:0];
          10'h002: byte_mux = max_ms[15:8];
          10'h003: byte_mux = max_ms[7:0];
          default: byte_mux = status_reg[{st_node[4:0], 3'b000} +: 8];
        endcase
      ldch_pkg::CMD_ECHO:
        byte_mux = echo_mem[idx_reg[8:0]];
      ldch_pkg::CMD_BC_RESULTS:
        byte_mux = bc_snap[idx_reg[5:0]];
      ldch_pkg::CMD_LOG_READ:
        case (idx_reg)
          10'h000: byte_mux = ldch_pkg::LOG_CAPACITY[15:8];
          10'h001: byte_mux = ldch_pkg::LOG_CAPACITY[7:0];
          10'h002: byte_mux = 8'h00;
          10'h003: byte_mux = {2'b00, log_count};
          10'h004: byte_mux = len_hdr[15:8];
          10'h005: byte_mux = len_hdr[7:0];
          10'h006: byte_mux = 8'h00;
          10'h007: byte_mux = 8'h00;
          // Timestamp bytes stored in BCD as written
          default: byte_mux = log_rec[79 - {rb_reg, 3'b000} -: 8];
        endcase
      default:
        byte_mux = 8'h00;
    endcase
  end

  // Snapshot of counts taken on the read that clears them
  generate
    for (n = 0; n < ldch_pkg::NODES; n++)
    begin : g_snap
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
          bc_snap[n] <= 8'h00;
        else if (bc_clear)
          bc_snap[n] <= bc_cnt_reg[n];
      end
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (cmd_valid_in)
          case (cmd_code_in)
            ldch_pkg::CMD_ECHO: state_next = S_ECHO_IN;
            ldch_pkg::CMD_BC_SEND: state_next = S_BC_IN;
            ldch_pkg::CMD_LOG_CLEAR: state_next = S_DONE;
            default: state_next = S_SEND;
          endcase
      S_ECHO_IN:
        // Full store: the rest of the payload is drained
        if (!echo_room)
          state_next = S_DRAIN;
        else if (pay_valid_in && pay_last_in)
          state_next = S_SEND;
      S_DRAIN:
        if (pay_valid_in && pay_last_in)
          state_next = S_SEND;
      S_BC_IN:
        if (pay_valid_in && pay_last_in)
          state_next = S_IDLE;
      S_SEND:
        if (rsp_fire && is_last)
          state_next = S_IDLE;
      S_DONE:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // Byte indexes and lengths
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_reg <= 4'h0;
      idx_reg <= 10'h000;
      len_reg <= 10'h001;
      rb_reg <= 4'h0;
      log_idx_reg <= 6'h00;
      code_reg <= ldch_pkg::END_NORMAL;
      len_hdr <= 16'h0000;
    end
    else if (take)
    begin
      op_reg <= cmd_code_in;
      idx_reg <= 10'h000;
      rb_reg <= 4'h0;
      code_reg <= ldch_pkg::END_NORMAL;
      case (cmd_code_in)
        ldch_pkg::CMD_LINK_STATUS: len_reg <= 10'(4 + ldch_pkg::STATUS_BYTES);
        ldch_pkg::CMD_BC_RESULTS: len_reg <= 10'(ldch_pkg::NODES);
        ldch_pkg::CMD_LOG_READ:
        begin
          len_reg <= log_hdr_len + {4'h0, grant[5:0]} * 10'h00a;
          len_hdr <= grant;
          log_idx_reg <= start_rec[5:0];
          code_reg <= log_code;
        end
        default: len_reg <= 10'h001;
      endcase
    end
    else if (pay_take && state_reg == S_ECHO_IN)
    begin
      // Length caps at 512; excess bytes are drained unanswered
      if (echo_room)
        idx_reg <= idx_reg + 10'h001;
      if (pay_last_in)
      begin
        len_reg <= echo_room ? idx_reg + 10'h001 : ldch_pkg::ECHO_MAX_W;
        idx_reg <= 10'h000;
      end
    end
    else if (state_reg == S_DRAIN && pay_valid_in && pay_last_in)
    begin
      idx_reg <= 10'h000;
      len_reg <= ldch_pkg::ECHO_MAX_W;
    end
    else if (rsp_fire && !is_last)
    begin
      idx_reg <= idx_reg + 10'h001;
      if (op_reg == ldch_pkg::CMD_LOG_READ && idx_reg >= log_hdr_len)
      begin
        if (rb_reg == ldch_pkg::REC_LAST)
        begin
          rb_reg <= 4'h0;
          log_idx_reg <= log_idx_reg + 6'h01;
        end
        else
          rb_reg <= rb_reg + 4'h1;
      end
    end
  end

  // Echo store, written as bytes arrive
  always_ff @(posedge clk_in)
  begin
    if (pay_take && state_reg == S_ECHO_IN && echo_room)
      echo_mem[idx_reg[8:0]] <= pay_data_in;
  end
endmodule
`default_nettype wire

// [verification/ldch_top_asserts.sv]
// Purpose: port checker for the diagnostic command handler
// Assumes: one clock, nrst_in low resets everything
// Notes: response lengths tracked by a small beat counter
`timescale 1ns/1ps
`default_nettype none
module ldch_top_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Command and payload
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic cmd_ready_out,
  input wire logic pay_valid_in,
  input wire logic pay_last_in,
  input wire logic pay_ready_out,
  // Response and delivery
  input wire logic rsp_valid_out,
  input wire logic [7:0] rsp_data_out,
  input wire logic rsp_last_out,
  input wire logic rsp_ready_in,
  input wire logic bc_deliver_out
);
  // ----------------------------------------
  // Beat tracking
  // ----------------------------------------
  logic [3:0] kind_reg;
  logic [9:0] beat_reg;
  wire take_w = cmd_valid_in && cmd_ready_out;
  wire beat_w = rsp_valid_out && rsp_ready_in;
  wire ans_w = take_w && (cmd_code_in inside {4'h1, 4'h3, 4'h5});
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      kind_reg <= 4'h0;
      beat_reg <= 10'h000;
    end
    else if (take_w)
    begin
      kind_reg <= cmd_code_in;
      beat_reg <= 10'h000;
    end
    else if (beat_w)
      beat_reg <= beat_reg + 10'h001;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RSP_HOLD:
    assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out
      && $stable(rsp_data_out) && $stable(rsp_last_out))
    else $error("Response byte changed before taken");
  AST_ANSWER:
    assert property (ans_w |=> rsp_valid_out)
    else $error("Read command not answered next cycle");
  AST_BUSY:
    assert property (ans_w || take_w && cmd_code_in == 4'h2 |=> !cmd_ready_out)
    else $error("Command accepted while busy");
  AST_BC_LAST:
    assert property (bc_deliver_out |-> pay_valid_in && pay_ready_out && pay_last_in)
    else $error("Delivery without last payload byte");
  AST_BC_SILENT:
    assert property (bc_deliver_out |=> !rsp_valid_out [*8])
    else $error("Broadcast send produced a response");
  AST_CLEAR_SILENT:
    assert property (take_w && cmd_code_in == 4'h6 |=> !rsp_valid_out [*4])
    else $error("Log clear produced a response");
  AST_STATUS_LEN:
    assert property (beat_w && rsp_last_out && kind_reg == 4'h1 |-> beat_reg == 10'h022)
    else $error("Status response length wrong");
  AST_RESULTS_LEN:
    assert property (beat_w && rsp_last_out && kind_reg == 4'h3 |-> beat_reg == 10'h03d)
    else $error("Results response length wrong");
  AST_ECHO_MAX:
    assert property (beat_w && kind_reg == 4'h2 |-> beat_reg < 10'h200)
    else $error("Echo longer than limit");
  AST_LOG_SHAPE:
    assert property (beat_w && rsp_last_out && kind_reg == 4'h5 |-> beat_reg >= 10'h007
      && (beat_reg - 10'h007) % 10'h00a == 10'h000)
    else $error("Log response not whole records");
  AST_LOG_CAP:
    assert property (beat_w && kind_reg == 4'h5 && beat_reg == 10'h001
      |-> rsp_data_out == 8'h27)
    else $error("Log capacity byte wrong");
endmodule
bind ldch_top ldch_top_asserts ldch_top_asserts_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in), .cmd_ready_out(cmd_ready_out),
  .pay_valid_in(pay_valid_in), .pay_last_in(pay_last_in), .pay_ready_out(pay_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .rsp_last_out(rsp_last_out),
  .rsp_ready_in(rsp_ready_in), .bc_deliver_out(bc_deliver_out));
`default_nettype wire

// [verification/ldch_rsp_sink.sv]
// Purpose: host side taking response bytes
// Assumes: phase advances on the falling edge
// Notes: slow mode is ready one cycle in four
`timescale 1ns/1ps
`default_nettype none
module ldch_rsp_sink (
  // Clock
  input wire logic clk_in,
  // Control and handshake
  input wire logic slow_in,
  output logic ready_out
);
  logic [1:0] phase_reg = 2'h0;
  always @(negedge clk_in)
    phase_reg <= phase_reg + 2'h1;
  // Stalls expose held bytes; frames stay within 540 bytes
  assign ready_out = !slow_in || (phase_reg == 2'h3);
endmodule
`default_nettype wire

// [verification/ldch_top_tb.sv]
// Purpose: self-checking bench of the command handler
// Assumes: inputs change on the falling edge
// Notes: refresh figures checked only at the REFRESH_MIN clamp, counts take ms
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module ldch_top_tb;
  logic clk_in = 1'b0, nrst_in = 1'b0, cmd_valid = 1'b0, given = 1'b0;
  logic pay_valid = 1'b0, pay_last = 1'b0, link_run = 1'b0, cycle_done = 1'b0;
  logic bc_rx = 1'b0, log_wr = 1'b0, slow = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [15:0] arg0 = 16'h0000, arg1 = 16'h0000;
  logic [7:0] pay_data = 8'h00;
  logic [247:0] node_st = '0, pa = '0;
  logic [5:0] bc_node = 6'h01;
  logic [79:0] log_rec = '0;
  logic cmd_ready, pay_ready, rsp_valid, rsp_last, rsp_ready, bc_deliver;
  logic [7:0] rsp_data;
  logic [1:0] rsp_code, code_got;
  logic [7:0] q[$];
  int num_errors = 0, num_checks = 0, n_deliv = 0, i;
  ldch_top ldch_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_arg0_in(arg0), .cmd_arg1_in(arg1),
    .cmd_count_given_in(given), .cmd_ready_out(cmd_ready), .pay_valid_in(pay_valid),
    .pay_data_in(pay_data), .pay_last_in(pay_last), .pay_ready_out(pay_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_last_out(rsp_last),
    .rsp_end_code_out(rsp_code), .rsp_ready_in(rsp_ready), .bc_deliver_out(bc_deliver),
    .link_run_in(link_run), .cycle_done_in(cycle_done), .node_status_in(node_st),
    .bc_rx_in(bc_rx), .bc_rx_node_in(bc_node), .log_wr_in(log_wr), .log_rec_in(log_rec));
  ldch_rsp_sink ldch_rsp_sink_i (.clk_in(clk_in), .slow_in(slow), .ready_out(rsp_ready));
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (bc_deliver === 1'b1) n_deliv++;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    tally_and_finish();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] a0, a1, input logic g);
    cmd_code = c;
    arg0 = a0;
    arg1 = a1;
    given = g;
    cmd_valid = 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk_in);
      if (cmd_ready === 1'b1) break;
    end
    if (i == 200) hang();
    @(negedge clk_in);
    cmd_valid = 1'b0;
  endtask
  task automatic collect();
    q.delete();
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk_in);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) q.push_back(rsp_data);
      code_got = rsp_code;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1 && rsp_last === 1'b1) break;
    end
    if (i == 3000) hang();
    @(negedge clk_in);
  endtask
  task automatic send(input int n);
    for (int k = 0; k < n; k++)
    begin
      pay_data = 8'(k) ^ 8'h5a;
      pay_last = (k == n - 1);
      pay_valid = 1'b1;
      for (i = 0; i < 200; i++)
      begin
        @(posedge clk_in);
        if (pay_ready === 1'b1) break;
      end
      if (i == 200) hang();
      @(negedge clk_in);
    end
    pay_valid = 1'b0;
    pay_last = 1'b0;
  endtask
  function automatic logic [79:0] rec(input int k);
    return {8'(k + 1), 8'h00, 8'h59, 8'h30, 8'h23, 8'h15, 8'h07, 8'h24, 16'(k)};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_status();
    link_run = 1'b1;
    node_st = pa;
    repeat (6)
    begin
      cycle_done = 1'b1;
      cyc(4);
      cycle_done = 1'b0;
      cyc(4);
    end
    link_run = 1'b0;
    cyc(6);
    node_st = ~pa;
    // A cycle end while halted must not refresh anything
    cycle_done = 1'b1;
    cyc(4);
    cycle_done = 1'b0;
    cyc(4);
    cmd(ldch_pkg::CMD_LINK_STATUS, 16'h0000, 16'h0000, 1'b0);
    collect();
    `CHK(q.size(), 35)
    `CHK(q[0], 8'h00)
    `CHK(q[2], 8'h00)
    `CHK(q[1], ldch_pkg::REFRESH_MIN[7:0])
    `CHK(q[3], ldch_pkg::REFRESH_MIN[7:0])
    for (int k = 0; k < 31; k++) `CHK(q[4 + k], pa[8 * k +: 8])
  endtask
  task automatic t_echo();
    cmd(ldch_pkg::CMD_ECHO, 16'h0000, 16'h0000, 1'b0);
    send(514);
    collect();
    `CHK(q.size(), 512)
    for (int k = 0; k < 512; k++) `CHK(q[k], 8'(k) ^ 8'h5a)
  endtask
  task automatic t_bcast();
    // Sent to node FF, unit FE, answer suppressed
    cmd(ldch_pkg::CMD_BC_SEND, 16'h0000, 16'h0000, 1'b0);
    send(8);
    cyc(10);
    `CHK(n_deliv, 1)
    `CHK(rsp_valid, 1'b0)
    for (int k = 0; k < 4; k++)
    begin
      bc_node = (k == 3) ? ldch_pkg::NODE_LAST : ldch_pkg::NODE_FIRST;
      bc_rx = 1'b1;
      cyc(1);
      bc_rx = 1'b0;
      cyc(1);
    end
    for (int r = 0; r < 2; r++)
    begin
      cmd(ldch_pkg::CMD_BC_RESULTS, 16'h0000, 16'h0000, 1'b0);
      collect();
      `CHK(q.size(), 62)
      for (int k = 0; k < 62; k++)
        `CHK(q[k], (r == 1) ? 8'h00 : (k == 0) ? 8'h03 : (k == 61) ? 8'h01 : 8'h00)
    end
  endtask
  task automatic chk_log(input int s, n, st, input logic [1:0] c);
    logic [79:0] r;
    `CHK(q.size(), 8 + 10 * n)
    `CHK({q[0], q[1]}, ldch_pkg::LOG_CAPACITY)
    `CHK(q[3], 8'(st))
    `CHK(q[5], 8'(n))
    `CHK(code_got, c)
    for (int j = 0; j < 10 * n; j++)
    begin
      r = rec(s + j / 10);
      `CHK(q[8 + j], r[79 - 8 * (j % 10) -: 8])
    end
  endtask
  task automatic t_log();
    for (int k = 0; k < 5; k++)
    begin
      log_rec = rec(k);
      log_wr = 1'b1;
      cyc(1);
      log_wr = 1'b0;
      cyc(2);
    end
    cmd(ldch_pkg::CMD_LOG_READ, 16'h0001, 16'h0003, 1'b1);
    collect();
    chk_log(1, 3, 5, ldch_pkg::END_NORMAL);
    cmd(ldch_pkg::CMD_LOG_READ, 16'h0000, 16'h0007, 1'b1);
    collect();
    chk_log(0, 5, 5, ldch_pkg::END_RANGE_OVF);
    cmd(ldch_pkg::CMD_LOG_READ, 16'h0000, 16'h0028, 1'b1);
    collect();
    chk_log(0, 5, 5, ldch_pkg::END_LEN_OVF);
    cmd(ldch_pkg::CMD_LOG_READ, 16'h0000, 16'h0000, 1'b0);
    collect();
    chk_log(0, 5, 5, ldch_pkg::END_NORMAL);
    cmd(ldch_pkg::CMD_LOG_CLEAR, 16'h0000, 16'h0000, 1'b0);
    cyc(6);
    cmd(ldch_pkg::CMD_LOG_READ, 16'h0000, 16'h0000, 1'b0);
    collect();
    chk_log(0, 0, 0, ldch_pkg::END_NORMAL);
  endtask
  initial
  begin
    for (int k = 0; k < 31; k++) pa[8 * k +: 8] = 8'(k * 7 + 3);
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    cyc(5);
    t_status();
    slow = 1'b1;
    t_echo();
    t_bcast();
    slow = 1'b0;
    t_log();
    tally_and_finish();
  end
endmodule
`default_nettype wire
